// [pkg/uart_bridge_defines.svh]
// Constants for the octal serial host access and mode select block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef UART_BRIDGE_DEFINES_SVH
`define UART_BRIDGE_DEFINES_SVH
// Configuration space dword offsets (byte offset / 4)
`define CFG_IDX_ID        10'h000
`define CFG_IDX_CMD       10'h001
`define CFG_IDX_CLASS     10'h002
`define CFG_IDX_IO_BAR    10'h004
`define CFG_IDX_MEM_BAR   10'h005
`define CFG_COMPAT_BYTES  256
`define CFG_TOTAL_BYTES   4096
// Command register bits
`define CMD_IO_EN_BIT     0
`define CMD_MEM_EN_BIT    1
// Window sizes as address bit counts
`define IO_WIN_BITS       6
`define MEM_WIN_BITS      12
// Channel block layout
`define CHAN_BLOCK_BITS   3
`define CHAN_SEL_BITS     3
`define MEM_ENH_BIT       6
// FIFO depths
`define DEPTH_BYTE        8'h01
`define DEPTH_LEGACY      8'h10
`define DEPTH_DEEP        8'h80
`endif

// [pkg/uart_bridge_pkg.sv]
// Types shared by the host access and mode select block.
// Assumes the defines header is on the include path.
package uart_bridge_pkg;
`include "uart_bridge_defines.svh"
   typedef enum logic [1:0] {KIND_CFG0, KIND_IO, KIND_MEM, KIND_OTHER} req_kind_type;
   typedef enum logic [1:0] {MODE_LEGACY, MODE_DEEP, MODE_EXTENDED} chan_mode_type;
   typedef struct packed {
      req_kind_type kind;     // Transaction class
      logic         mmcfg;    // Config reached by memory-mapped addressing
      logic         wr;       // Write when set
      logic [31:0]  addr;     // Byte address
      logic [31:0]  wdata;    // Write data
   } host_req_type;
   typedef struct packed {
      logic [2:0] chan;       // Target channel
      logic [2:0] reg_off;    // Register inside the 8-byte block
      logic       enh;        // Enhanced register bank
      logic       wr;         // Write when set
      logic [7:0] wdata;      // Write byte
   } chan_acc_type;
endpackage

// [verilog/uart_host_access_mode_select.sv]
// Host access decoding, config space and per-channel mode selection.
// Assumes requests already parsed from packets on the same clock,
// and per-channel function bits supplied by the channel logic.
//
// Notes on behaviour
// - One function, identifiable by ID registers
// - Type 0 config reads/writes always completed
// - Low 256 bytes same via both paths
// - Upper config only by memory-mapped access
// - I/O window hit means I/O access
// - Memory window hit means memory access
// - Eight channels behind one host port
// - Each channel owns an 8-byte block
// - Enhanced bank only through memory window
// - Basic registers identical via I/O, memory
// - Enhanced bits pick deep or extended mode
// - Enhanced bit clear forces legacy mode
// - Legacy without FIFOs buffers one byte
// - Legacy with FIFOs gives 16 entries
// - Enhanced modes give 128-byte FIFOs
`timescale 1ns/10ps
`include "uart_bridge_defines.svh"

module uart_host_access_mode_select #(
   parameter logic [15:0] VENDOR_CODE = 16'h0A5A,      // Arbitrary value
   parameter logic [15:0] DEVICE_CODE = 16'h0C3C,      // Arbitrary value
   parameter logic [31:0] CLASS_REV   = 32'h0700_0200, // Arbitrary value
   parameter int          NUM_CHAN    = 8
) (
   input  wire logic                                sys_clk_in,       // 125 MHz clock
   input  wire logic                                rstn_in,          // Async reset, low
   input  wire logic                                req_valid_in,     // Request strobe
   input  wire uart_bridge_pkg::host_req_type       req_in,           // Request fields
   input  wire logic [NUM_CHAN-1:0]                 enh_func_bit_in,  // Enhanced bit 4
   input  wire logic [NUM_CHAN-1:0]                 spec_func_bit_in, // Special bit 5
   input  wire logic [NUM_CHAN-1:0]                 fifo_en_in,       // Legacy FIFO enable
   output logic                                     cpl_valid_out,    // Config completion
   output logic [31:0]                              cpl_data_out,     // Config read data
   output logic                                     unclaimed_out,    // Request not claimed
   output logic                                     chan_valid_out,   // Channel access
   output uart_bridge_pkg::chan_acc_type            chan_acc_out,     // Channel access
   output uart_bridge_pkg::chan_mode_type [NUM_CHAN-1:0] mode_out,    // Per channel mode
   output logic [NUM_CHAN-1:0][7:0]                 depth_out         // Per channel depth
);
   import uart_bridge_pkg::*;

   // ************************************************************
   // Configuration space
   // ************************************************************
   logic [1:0]                   cmd_r;
   logic [31:`IO_WIN_BITS]       io_bar_r;
   logic [31:`MEM_WIN_BITS]      mem_bar_r;
   logic                         cpl_valid_r;
   logic [31:0]                  cpl_data_r;
   logic                         unclaimed_r;
   logic                         chan_valid_r;
   chan_acc_type                 chan_acc_r;

   // Conventional addressing only carries 64 dwords, so the upper bits are
   // forced to zero and both paths land on the same low registers.
   wire logic [9:0] cfg_idx = req_in.mmcfg ? req_in.addr[11:2]
                                           : {4'h0, req_in.addr[7:2]};
   wire logic is_cfg   = req_valid_in && (req_in.kind == KIND_CFG0);
   wire logic cfg_wr   = is_cfg && req_in.wr;

   function automatic logic [31:0] cfg_read(input logic [9:0] idx);
      unique case (idx)
         `CFG_IDX_ID:      cfg_read = {DEVICE_CODE, VENDOR_CODE};
         `CFG_IDX_CMD:     cfg_read = {30'h0000_0000, cmd_r};
         `CFG_IDX_CLASS:   cfg_read = CLASS_REV;
         `CFG_IDX_IO_BAR:  cfg_read = {io_bar_r, 6'h01};
         `CFG_IDX_MEM_BAR: cfg_read = {mem_bar_r, 12'h000};
         default:          cfg_read = 32'h0000_0000; // Unused and extended space
      endcase
   endfunction

   // Register writes from type 0 config requests
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cmd_r     <= 2'h0;
         io_bar_r  <= '0;
         mem_bar_r <= '0;
      end else if (cfg_wr) begin
         if (cfg_idx == `CFG_IDX_CMD)     cmd_r     <= req_in.wdata[1:0];
         if (cfg_idx == `CFG_IDX_IO_BAR)  io_bar_r  <= req_in.wdata[31:`IO_WIN_BITS];
         if (cfg_idx == `CFG_IDX_MEM_BAR) mem_bar_r <= req_in.wdata[31:`MEM_WIN_BITS];
      end
   end

   // ************************************************************
   // Window decode
   // ************************************************************
   // Hits need the matching space enabled in the command register
   wire logic io_hit  = req_valid_in && (req_in.kind == KIND_IO) && cmd_r[`CMD_IO_EN_BIT]
                        && (req_in.addr[31:`IO_WIN_BITS] == io_bar_r);
   wire logic mem_hit = req_valid_in && (req_in.kind == KIND_MEM) && cmd_r[`CMD_MEM_EN_BIT]
                        && (req_in.addr[31:`MEM_WIN_BITS] == mem_bar_r);
   // Memory window: low 64 bytes mirror the I/O blocks, next 64 the enhanced bank
   wire logic mem_ok  = mem_hit && (req_in.addr[`MEM_WIN_BITS-1:`MEM_ENH_BIT+1] == '0);
   wire logic claim   = io_hit || mem_ok;
   wire logic [2:0] sel_chan = req_in.addr[`CHAN_BLOCK_BITS+`CHAN_SEL_BITS-1:`CHAN_BLOCK_BITS];

   // Completion and forwarding, one cycle after the request
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cpl_valid_r  <= 1'b0;
         cpl_data_r   <= 32'h0000_0000;
         unclaimed_r  <= 1'b0;
         chan_valid_r <= 1'b0;
         chan_acc_r   <= '0;
      end else begin
         cpl_valid_r  <= is_cfg;
         cpl_data_r   <= (is_cfg && !req_in.wr) ? cfg_read(cfg_idx) : 32'h0000_0000;
         unclaimed_r  <= req_valid_in && !is_cfg && !claim;
         chan_valid_r <= claim;
         if (claim) begin
            chan_acc_r.chan    <= sel_chan;
            chan_acc_r.reg_off <= req_in.addr[`CHAN_BLOCK_BITS-1:0];
            chan_acc_r.enh     <= mem_ok && req_in.addr[`MEM_ENH_BIT];
            chan_acc_r.wr      <= req_in.wr;
            chan_acc_r.wdata   <= req_in.wdata[7:0];
         end
      end
   end

   assign cpl_valid_out  = cpl_valid_r;
   assign cpl_data_out   = cpl_data_r;
   assign unclaimed_out  = unclaimed_r;
   assign chan_valid_out = chan_valid_r;
   assign chan_acc_out   = chan_acc_r;

   // ************************************************************
   // Per-channel mode and FIFO depth
   // ************************************************************
   for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
      chan_mode_type mode_nxt;
      logic [7:0]    depth_nxt;
      chan_mode_type mode_r;
      logic [7:0]    depth_r;
      // Special bit only matters once enhanced bit is set
      assign mode_nxt = !enh_func_bit_in[c] ? MODE_LEGACY
                        : (spec_func_bit_in[c] ? MODE_EXTENDED : MODE_DEEP);
      assign depth_nxt = (mode_nxt != MODE_LEGACY) ? `DEPTH_DEEP
                         : (fifo_en_in[c] ? `DEPTH_LEGACY
                                          : `DEPTH_BYTE);
      always_ff @(posedge sys_clk_in or negedge rstn_in) begin
         if (!rstn_in) begin
            mode_r  <= MODE_LEGACY;
            depth_r <= `DEPTH_BYTE;
         end else begin
            mode_r  <= mode_nxt;
            depth_r <= depth_nxt;
         end
      end
      assign mode_out[c]  = mode_r;
      assign depth_out[c] = depth_r;

      // Sampled reset in each trigger: the edge that releases reset still resets
      property p_legacy;
         @(posedge sys_clk_in) disable iff (!rstn_in)
         rstn_in && !enh_func_bit_in[c] |=> (mode_out[c] == MODE_LEGACY);
      endproperty
      a_legacy: assert property (p_legacy) else $error("legacy mode not chosen");
      property p_enh_mode;
         @(posedge sys_clk_in) disable iff (!rstn_in)
         rstn_in && enh_func_bit_in[c] |=> (mode_out[c] == (($past(spec_func_bit_in[c]))
                                 ? MODE_EXTENDED : MODE_DEEP)) && depth_out[c] == `DEPTH_DEEP;
      endproperty
      a_enh_mode: assert property (p_enh_mode) else $error("enhanced mode wrong");
      property p_leg_depth;
         @(posedge sys_clk_in) disable iff (!rstn_in)
         rstn_in && !enh_func_bit_in[c]
         |=> depth_out[c] == ($past(fifo_en_in[c]) ? `DEPTH_LEGACY : `DEPTH_BYTE);
      endproperty
      a_leg_depth: assert property (p_leg_depth) else $error("legacy depth wrong");
   end

   // ************************************************************
   // Checks
   // ************************************************************
   sequence s_cfg_req;
      req_valid_in && req_in.kind == KIND_CFG0;
   endsequence
   sequence s_cpl;
      cpl_valid_out && !chan_valid_out && !unclaimed_out;
   endsequence
   property p_cfg_cpl;
      @(posedge sys_clk_in) disable iff (!rstn_in) s_cfg_req |=> s_cpl;
   endproperty
   a_cfg_cpl: assert property (p_cfg_cpl) else $error("config request not completed");
   property p_id_read;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      s_cfg_req ##0 (!req_in.wr && req_in.addr[7:2] == 6'h00 && req_in.addr[11:8] == 4'h0)
      |=> cpl_data_out == {DEVICE_CODE, VENDOR_CODE};
   endproperty
   a_id_read: assert property (p_id_read) else $error("identity read wrong");
   property p_conv_alias;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      s_cfg_req ##0 (!req_in.wr && !req_in.mmcfg && req_in.addr[7:2] == 6'h00)
      |=> cpl_data_out == {DEVICE_CODE, VENDOR_CODE};
   endproperty
   a_conv_alias: assert property (p_conv_alias) else $error("conventional alias wrong");
   property p_io_fwd;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      io_hit |=> chan_valid_out && !chan_acc_out.enh
                 && chan_acc_out.chan == $past(req_in.addr[5:3]);
   endproperty
   a_io_fwd: assert property (p_io_fwd) else $error("io access not forwarded");
   property p_mem_fwd;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      mem_ok |=> chan_valid_out && chan_acc_out.reg_off == $past(req_in.addr[2:0])
                 && chan_acc_out.enh == $past(req_in.addr[6]);
   endproperty
   a_mem_fwd: assert property (p_mem_fwd) else $error("memory access not forwarded");
   property p_miss;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (req_valid_in && req_in.kind == KIND_IO && !io_hit) |=> unclaimed_out && !chan_valid_out;
   endproperty
   a_miss: assert property (p_miss) else $error("io miss claimed");
   // Memory offsets past both banks must not reach any channel
   property p_mem_beyond;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      (mem_hit && !mem_ok) |=> unclaimed_out && !chan_valid_out;
   endproperty
   a_mem_beyond: assert property (p_mem_beyond) else $error("memory offset past banks claimed");
   property p_io_basic;
      @(posedge sys_clk_in) disable iff (!rstn_in)
      io_hit |=> chan_acc_out.reg_off == $past(req_in.addr[2:0])
                 && chan_acc_out.wr == $past(req_in.wr);
   endproperty
   a_io_basic: assert property (p_io_basic) else $error("io access register wrong");
endmodule // uart_host_access_mode_select

// [tb/host_req_model.sv]
// Far-side host model: issues configuration, I/O and memory requests.
// Assumes the bench calls send() and the block samples on sys_clk_in.
`timescale 1ns/10ps
module host_req_model (
   input  wire logic                          sys_clk_in,    // Bench clock
   output logic                               req_valid_out, // Request strobe
   output uart_bridge_pkg::host_req_type      req_out        // Request fields
);
   import uart_bridge_pkg::*;
   // ****************************************
   // Request issue
   // ****************************************
   initial begin
      req_valid_out = 1'b0;
      req_out       = '0;
   end
   // One request held for one edge, then fields inverted so stale values never match
   task automatic send(input req_kind_type k, input logic m, input logic w,
                       input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      req_valid_out <= 1'b1;
      // Upper config space is never tried by conventional addressing
      req_out <= '{kind: k, mmcfg: m | (k == KIND_CFG0 && a[11:8] != 4'h0),
                   wr: w, addr: a, wdata: d};
      @(posedge sys_clk_in);
      req_valid_out <= 1'b0;
      req_out       <= ~req_out;
   endtask
endmodule // host_req_model

// [tb/uart_host_access_mode_select_tb.sv]
// Self-checking bench for the host access and mode select block.
// Assumes the package, its defines header and the host model are compiled first.
`timescale 1ns/10ps
module uart_host_access_mode_select_tb;
   import uart_bridge_pkg::*;
   localparam logic [15:0] VEND = 16'h5A5A;      // Arbitrary value
   localparam logic [15:0] DEV  = 16'h3C3C;      // Arbitrary value
   localparam logic [31:0] CLS  = 32'h0700_0200; // Arbitrary value
   localparam logic [31:0] IOB  = 32'h0000_2040; // 64-byte aligned
   localparam logic [31:0] MEMB = 32'hC000_3000; // 4 KB aligned
   logic                      sys_clk_in = 1'b0;
   logic                      rstn_in    = 1'b0;
   logic                      req_valid;
   host_req_type              req;
   logic [7:0]                enh        = 8'h00;
   logic [7:0]                spec       = 8'h00;
   logic [7:0]                fifo       = 8'h00;
   logic                      cpl_valid, unclaimed, chan_valid;
   logic [31:0]               cpl_data;
   chan_acc_type              acc_o;
   chan_mode_type [7:0]       mode;
   logic [7:0][7:0]           depth;
   int                        err_total = 0;
   int                        samples_checked = 0;
   // ****************************************
   // Clock, model and block under test
   // ****************************************
   always #4 sys_clk_in = ~sys_clk_in;
   host_req_model host_req_model_i (.sys_clk_in(sys_clk_in), .req_valid_out(req_valid),
                                    .req_out(req));
   uart_host_access_mode_select #(.VENDOR_CODE(VEND), .DEVICE_CODE(DEV), .CLASS_REV(CLS))
   uart_host_access_mode_select_i (
      .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .req_valid_in(req_valid),
      .req_in(req), .enh_func_bit_in(enh), .spec_func_bit_in(spec), .fifo_en_in(fifo),
      .cpl_valid_out(cpl_valid), .cpl_data_out(cpl_data), .unclaimed_out(unclaimed),
      .chan_valid_out(chan_valid), .chan_acc_out(acc_o), .mode_out(mode),
      .depth_out(depth));
   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Config access; completion lands one edge after the request
   task automatic cfg(input logic m, input logic w, input logic [31:0] a,
                      input logic [31:0] d, input logic [31:0] exp);
      host_req_model_i.send(KIND_CFG0, m, w, a, d);
      #1;
      chk("cpl_valid", {31'h0, cpl_valid}, 32'h1);
      chk("cpl_data", cpl_data, exp);
   endtask
   // I/O or memory access; either a claim or an unclaimed pulse
   task automatic xfer(input req_kind_type k, input logic w, input logic [31:0] a,
                       input logic [31:0] d, input logic hit, input logic e);
      host_req_model_i.send(k, 1'b0, w, a, d);
      #1;
      chk("claim", {30'h0, chan_valid, unclaimed}, hit ? 32'h2 : 32'h1);
      if (hit) chk("chan_acc", {16'h0, acc_o}, {16'h0, a[5:3], a[2:0], e, w, d[7:0]});
   endtask
   function automatic chan_mode_type exp_mode(input logic e, input logic s);
      return e ? (s ? MODE_EXTENDED : MODE_DEEP) : MODE_LEGACY;
   endfunction
   function automatic logic [7:0] exp_depth(input logic e, input logic f);
      return e ? 8'h80 : (f ? 8'h10 : 8'h01);
   endfunction
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #50000;
      err_total++;
      end_of_test();
   end
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      logic [31:0] o, d;
      logic        w;
      logic [7:0]  e, s, f;
      void'($urandom(32'h0132));
      repeat (6) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      cfg(1'b0, 1'b0, 32'h0000_0000, 32'h0, {DEV, VEND});
      cfg(1'b1, 1'b0, 32'h0000_0000, 32'h0, {DEV, VEND});
      cfg(1'b0, 1'b0, 32'h0000_0008, 32'h0, CLS);
      cfg(1'b1, 1'b0, 32'h0000_0108, 32'h0, 32'h0);
      cfg(1'b0, 1'b1, 32'h0000_0010, IOB, 32'h0);
      cfg(1'b1, 1'b0, 32'h0000_0010, 32'h0, IOB | 32'h1);
      cfg(1'b0, 1'b1, 32'h0000_0014, MEMB, 32'h0);
      cfg(1'b0, 1'b0, 32'h0000_0014, 32'h0, MEMB);
      // Decoding stays off until the command bits are set
      xfer(KIND_IO, 1'b1, IOB, 32'h55, 1'b0, 1'b0);
      cfg(1'b1, 1'b1, 32'h0000_0010, IOB, 32'h0);
      cfg(1'b0, 1'b1, 32'h0000_0004, 32'h3, 32'h0);
      cfg(1'b0, 1'b0, 32'h0000_0004, 32'h0, 32'h3);
      $display("Test config done");
      xfer(KIND_IO, 1'b1, IOB | 32'h1B, 32'hA7, 1'b1, 1'b0);
      xfer(KIND_MEM, 1'b1, MEMB | 32'h1B, 32'hA7, 1'b1, 1'b0);
      xfer(KIND_IO, 1'b0, IOB + 32'h40, 32'h0, 1'b0, 1'b0);
      xfer(KIND_MEM, 1'b0, MEMB | 32'h80, 32'h0, 1'b0, 1'b0);
      xfer(KIND_MEM, 1'b0, MEMB + 32'h1000, 32'h0, 1'b0, 1'b0);
      xfer(KIND_OTHER, 1'b0, IOB, 32'h0, 1'b0, 1'b0);
      repeat (40) begin
         o = $urandom & 32'h3F;
         w = 1'($urandom);
         d = $urandom;
         xfer(KIND_IO, w, IOB | o, d, 1'b1, 1'b0);
         o = $urandom & 32'h7F;
         xfer(KIND_MEM, w, MEMB | o, d, 1'b1, o[6]);
      end
      $display("Test access done");
      // First eight passes walk every bit combination on all channels
      for (int i = 0; i < 40; i++) begin
         e = (i < 8) ? {8{i[0]}} : 8'($urandom);
         s = (i < 8) ? {8{i[1]}} : 8'($urandom);
         f = (i < 8) ? {8{i[2]}} : 8'($urandom);
         @(posedge sys_clk_in);
         enh  <= e;
         spec <= s;
         fifo <= f;
         @(posedge sys_clk_in);
         #1;
         for (int c = 0; c < 8; c++) begin
            chk("mode", {30'h0, mode[c]}, {30'h0, exp_mode(e[c], s[c])});
            chk("depth", {24'h0, depth[c]}, {24'h0, exp_depth(e[c], f[c])});
         end
      end
      $display("Test mode done");
      // Mid-run reset: modes fall back to legacy and the command bits clear
      @(posedge sys_clk_in);
      rstn_in <= 1'b0;
      @(posedge sys_clk_in);
      #1;
      chk("rst_mode", {16'h0, mode}, 32'h0000_0000);
      chk("rst_depth_lo", depth[3:0], {4{8'h01}});
      chk("rst_depth_hi", depth[7:4], {4{8'h01}});
      @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      xfer(KIND_IO, 1'b0, IOB, 32'h0, 1'b0, 1'b0);
      $display("Test reset done");
      end_of_test();
   end
endmodule // uart_host_access_mode_select_tb
